// ---- common/isf_defs.vh ----
`ifndef ISF_DEFS_VH
`define ISF_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (4-bit register port address)
// ----------------------------------------------------------------
`define ISF_OFS_PRIMARY_ADDR 4'h0
`define ISF_OFS_FIRST_CTRL 4'h2
`define ISF_OFS_STATUS 4'h3
`define ISF_OFS_DATA 4'h4
`define ISF_OFS_SECOND_CTRL 4'h5
`define ISF_OFS_RANGE_ADDR 4'h6
`define ISF_OFS_SMB_CTRL 4'h7
`define ISF_OFS_SECOND_ADDR 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISF_BIT_DONE 7
`define ISF_BIT_ADDRESSED 6
`define ISF_BIT_BUSY 5
`define ISF_BIT_RW 2
`define ISF_BIT_TX_SELECT 4
`define ISF_BIT_GC_EN 7
`define ISF_BIT_RANGE_EN 3
`define ISF_BIT_ALERT_EN 3
`define ISF_BIT_SECOND_EN 1

// ----------------------------------------------------------------
// Reset values and fixed bus addresses
// ----------------------------------------------------------------
`define ISF_RST_BYTE 8'h00
`define ISF_GENERAL_CALL_ADDR 7'h00
`define ISF_ALERT_RESPONSE_ADDR 7'h0C

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define ISF_SYNC_STAGES 2
`define ISF_BITS_PER_BYTE 4'h8
`define ISF_ACK_SLOT 4'h9

`endif

// ---- logic/isf_line_watch.v ----
`timescale 1ns/1ps
`include "isf_defs.vh"

// Samples the two bus lines into the local clock and finds
// clock edges plus START and STOP conditions.
module isf_line_watch (
    input wire clock,
    input wire arst_n,
    input wire scl_in,
    input wire sda_in,
    output reg scl_level,
    output reg sda_level,
    output reg scl_rise,
    output reg scl_fall,
    output reg start_seen,
    output reg stop_seen
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    // First stage feeds only the second stage; nothing else looks
    reg scl_meta;
    reg sda_meta;
    reg scl_sync;
    reg sda_sync;

    // Two flip-flops per line before any logic reads it
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_meta <= 1'b1;
            sda_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            sda_meta <= sda_in;
            scl_sync <= scl_meta;
            sda_sync <= sda_meta;
        end
    end

    // ------------------------------------------------------------
    // Edge and condition detection
    // ------------------------------------------------------------
    // Delayed copies give edges; SDA moving while SCL high is a
    // START (falling) or STOP (rising) condition
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_level <= 1'b1;
            sda_level <= 1'b1;
            scl_rise <= 1'b0;
            scl_fall <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            scl_level <= scl_sync;
            sda_level <= sda_sync;
            scl_rise <= scl_sync & ~scl_level;
            scl_fall <= ~scl_sync & scl_level;
            start_seen <= scl_sync & scl_level & sda_level & ~sda_sync;
            stop_seen <= scl_sync & scl_level & ~sda_level & sda_sync;
        end
    end

endmodule // isf_line_watch

// ---- logic/isf_status_flags.v ----
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "isf_defs.vh"

// Summary of operation
// - Completion of a byte we are addressed in sets transfer_done_flag, status bit 7
// - Data read in receive, write in transmit clears
// - Done flag low during byte, high after
// - Primary match or enabled nonzero range match sets addressed
// - Enabled general call sets addressed flag
// - Enabled second address match sets addressed flag
// - Enabled alert response address sets addressed flag
// - Enabled range between primary and range sets
// - Addressed flag set before address acknowledge bit
// - First control write clears addressed flag unless a match sets it in the same cycle
// - START sets busy bit 5, STOP clears
// - Busy tracks bus in every mode
// - Transmit select: 0 receive, 1 transmit
// - Present received read/write bit, 0 means write
module isf_status_flags (
    input wire clock,
    input wire arst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire scl_in,
    input wire sda_in,
    output reg transfer_done_flag,
    output reg target_addressed_flag,
    output reg bus_busy_flag,
    output reg target_rw_indication
);

    // ------------------------------------------------------------
    // Bus line watcher
    // ------------------------------------------------------------
    wire sda_level;
    wire scl_rise;
    wire scl_fall;
    wire start_seen;
    wire stop_seen;

    // Clock level is only needed inside the watcher for its edges
    isf_line_watch i_isf_line_watch (
        .clock(clock),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_level(),
        .sda_level(sda_level),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen)
    );

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    reg [7:0] primary_target_address_reg;
    reg [7:0] range_target_address_reg;
    reg [7:0] second_target_address_reg;
    reg [7:0] first_control_reg;
    reg [7:0] second_control_reg;
    reg [7:0] smb_control_reg;
    reg [7:0] tx_data_reg;
    reg [7:0] rx_data_reg;

    wire tx_select;
    wire general_call_enable;
    wire range_match_enable;
    wire alert_response_enable;
    wire second_address_enable;

    assign tx_select = first_control_reg[`ISF_BIT_TX_SELECT];
    assign general_call_enable = second_control_reg[`ISF_BIT_GC_EN];
    assign range_match_enable = second_control_reg[`ISF_BIT_RANGE_EN];
    assign alert_response_enable = smb_control_reg[`ISF_BIT_ALERT_EN];
    assign second_address_enable = smb_control_reg[`ISF_BIT_SECOND_EN];

    // Decoded one-cycle accesses
    wire wr_first_ctrl;
    wire wr_data;
    wire rd_data;

    assign wr_first_ctrl = reg_write && (reg_addr == `ISF_OFS_FIRST_CTRL);
    assign wr_data = reg_write && (reg_addr == `ISF_OFS_DATA);
    assign rd_data = reg_read && (reg_addr == `ISF_OFS_DATA);

    // Plain storage registers; status has no write path at all, so
    // a write to it cannot disturb the hardware flags
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            primary_target_address_reg <= `ISF_RST_BYTE;
            range_target_address_reg <= `ISF_RST_BYTE;
            second_target_address_reg <= `ISF_RST_BYTE;
            first_control_reg <= `ISF_RST_BYTE;
            second_control_reg <= `ISF_RST_BYTE;
            smb_control_reg <= `ISF_RST_BYTE;
            tx_data_reg <= `ISF_RST_BYTE;
        end else if (reg_write) begin
            case (reg_addr)
                `ISF_OFS_PRIMARY_ADDR: begin
                    primary_target_address_reg <= reg_wdata;
                end
                `ISF_OFS_RANGE_ADDR: begin
                    range_target_address_reg <= reg_wdata;
                end
                `ISF_OFS_SECOND_ADDR: begin
                    second_target_address_reg <= reg_wdata;
                end
                `ISF_OFS_FIRST_CTRL: begin
                    first_control_reg <= reg_wdata;
                end
                `ISF_OFS_SECOND_CTRL: begin
                    second_control_reg <= reg_wdata;
                end
                `ISF_OFS_SMB_CTRL: begin
                    smb_control_reg <= reg_wdata;
                end
                `ISF_OFS_DATA: begin
                    tx_data_reg <= reg_wdata;
                end
                default: begin
                    tx_data_reg <= tx_data_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address matching
    // ------------------------------------------------------------
    // Address fields sit in bits 7:1, as on the wire
    function [6:0] isf_addr;
        input [7:0] field;
        begin
            isf_addr = field[7:1];
        end
    endfunction

    // Returns one when a received calling address targets us
    function isf_match;
        input [6:0] call;
        input [6:0] prim;
        input [6:0] rng;
        input [6:0] sec;
        input rng_en;
        input gc_en;
        input sec_en;
        input alert_en;
        begin
            isf_match = (call == prim)
                || (rng_en && rng != 7'h00 && call == rng)
                || (gc_en && call == `ISF_GENERAL_CALL_ADDR)
                || (sec_en && call == sec)
                || (alert_en && call == `ISF_ALERT_RESPONSE_ADDR)
                || (rng_en && call > prim && call <= rng);
        end
    endfunction

    // ------------------------------------------------------------
    // Bit tracking within a frame
    // ------------------------------------------------------------
    reg [3:0] bit_count;
    reg [7:0] shift_byte;
    reg first_byte;
    reg engaged;

    wire address_ready;
    wire byte_finished;
    wire byte_begins;
    wire call_matches;

    // Eighth bit captured, SCL falls: ACK slot has not yet begun
    assign address_ready = scl_fall && first_byte
        && (bit_count == `ISF_BITS_PER_BYTE);
    // Falling SCL after the ACK slot ends the byte
    assign byte_finished = scl_fall && (bit_count == `ISF_ACK_SLOT);
    // First data bit of the next byte
    assign byte_begins = scl_rise && (bit_count == 4'h0);
    assign call_matches = isf_match(shift_byte[7:1],
        isf_addr(primary_target_address_reg),
        isf_addr(range_target_address_reg),
        isf_addr(second_target_address_reg),
        range_match_enable, general_call_enable,
        second_address_enable, alert_response_enable);

    // Counts data bits and the ACK slot; a (repeated) START opens
    // a fresh address byte, a STOP parks the counter
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bit_count <= 4'h0;
            shift_byte <= `ISF_RST_BYTE;
            first_byte <= 1'b0;
            engaged <= 1'b0;
        end else if (start_seen) begin
            bit_count <= 4'h0;
            first_byte <= 1'b1;
            engaged <= 1'b0;
        end else if (stop_seen) begin
            bit_count <= 4'h0;
            first_byte <= 1'b0;
            engaged <= 1'b0;
        end else begin
            if (scl_rise && bit_count < `ISF_BITS_PER_BYTE) begin
                shift_byte <= {shift_byte[6:0], sda_level};
                bit_count <= bit_count + 4'h1;
            end else if (scl_rise && bit_count == `ISF_BITS_PER_BYTE) begin
                bit_count <= `ISF_ACK_SLOT;
            end else if (byte_finished) begin
                bit_count <= 4'h0;
                first_byte <= 1'b0;
            end
            if (address_ready && call_matches) begin
                engaged <= 1'b1;
            end
        end
    end

    // Last complete byte is kept for the data register
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_reg <= `ISF_RST_BYTE;
        end else if (address_ready || (byte_finished && !first_byte)) begin
            rx_data_reg <= shift_byte;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Busy follows START and STOP whatever our role
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bus_busy_flag <= 1'b0;
        end else if (start_seen) begin
            bus_busy_flag <= 1'b1;
        end else if (stop_seen) begin
            bus_busy_flag <= 1'b0;
        end
    end

    // Addressed flag rises at the eighth falling edge, ahead of the
    // ACK slot; a first control write clears it but a match in
    // the same cycle wins
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            target_addressed_flag <= 1'b0;
        end else if (address_ready && call_matches) begin
            target_addressed_flag <= 1'b1;
        end else if (wr_first_ctrl) begin
            target_addressed_flag <= 1'b0;
        end
    end

    // Read/write bit of the calling address; 0 = remote writes
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            target_rw_indication <= 1'b0;
        end else if (address_ready && call_matches) begin
            target_rw_indication <= shift_byte[0];
        end
    end

    // Done flag: set at the end of each byte we take part in,
    // low again once the next byte starts or software services
    // the data register in the direction selected
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            transfer_done_flag <= 1'b0;
        end else if (byte_finished && (engaged || first_byte
            && call_matches)) begin
            transfer_done_flag <= 1'b1;
        end else if (byte_begins) begin
            transfer_done_flag <= 1'b0;
        end else if ((rd_data && !tx_select) || (wr_data && tx_select)) begin
            transfer_done_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Composed status byte; unused bits read zero
    wire [7:0] status_byte;

    assign status_byte = {transfer_done_flag, target_addressed_flag,
        bus_busy_flag, 2'b00, target_rw_indication, 2'b00};

    // Data stands only in the cycle after the read strobe, which
    // keeps stale values from being mistaken for fresh ones
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `ISF_RST_BYTE;
        end else if (reg_read) begin
            case (reg_addr)
                `ISF_OFS_PRIMARY_ADDR: begin
                    reg_rdata <= primary_target_address_reg;
                end
                `ISF_OFS_FIRST_CTRL: begin
                    reg_rdata <= first_control_reg;
                end
                `ISF_OFS_STATUS: begin
                    reg_rdata <= status_byte;
                end
                `ISF_OFS_DATA: begin
                    reg_rdata <= tx_select ? tx_data_reg : rx_data_reg;
                end
                `ISF_OFS_SECOND_CTRL: begin
                    reg_rdata <= second_control_reg;
                end
                `ISF_OFS_RANGE_ADDR: begin
                    reg_rdata <= range_target_address_reg;
                end
                `ISF_OFS_SMB_CTRL: begin
                    reg_rdata <= smb_control_reg;
                end
                `ISF_OFS_SECOND_ADDR: begin
                    reg_rdata <= second_target_address_reg;
                end
                default: begin
                    reg_rdata <= `ISF_RST_BYTE;
                end
            endcase
        end else begin
            reg_rdata <= `ISF_RST_BYTE;
        end
    end

endmodule // isf_status_flags

// ---- bench/isf_status_flags_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the status flags
// ----------------------------------------------------------------
module isf_status_flags_properties (
    input wire clock,
    input wire arst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire scl_in,
    input wire sda_in,
    input wire transfer_done_flag,
    input wire target_addressed_flag,
    input wire bus_busy_flag,
    input wire target_rw_indication
);
    // Status byte as software should see it
    wire [7:0] status_now = {transfer_done_flag, target_addressed_flag,
        bus_busy_flag, 2'b00, target_rw_indication, 2'b00};
    wire [2:0] flags_now = status_now[7:5];

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Quiet lines leave no edge pending in the synchroniser
    sequence lines_still;
        ($stable(scl_in) && $stable(sda_in)) [*6];
    endsequence
    sequence start_cond;
        $fell(sda_in) && scl_in;
    endsequence
    sequence stop_cond;
        $rose(sda_in) && scl_in;
    endsequence

    busy_set_a: assert property (start_cond |-> ##[1:8] bus_busy_flag)
        else $error("busy not set after start");
    busy_clr_a: assert property (stop_cond |-> ##[1:8] !bus_busy_flag)
        else $error("busy not cleared after stop");
    busy_hold_a: assert property (bus_busy_flag && !scl_in
        |=> bus_busy_flag)
        else $error("busy dropped with clock line low");
    busy_edge_a: assert property ($rose(bus_busy_flag)
        |-> scl_in && !sda_in)
        else $error("busy rose without a start");
    ctrl_clear_a: assert property (lines_still ##0
        (reg_write && reg_addr == 4'h2) |=> !target_addressed_flag)
        else $error("control write left addressed flag");
    stat_write_a: assert property (lines_still ##0
        (reg_write && reg_addr == 4'h3) |=> flags_now == $past(flags_now))
        else $error("status write changed a flag");
    status_read_a: assert property (reg_read && reg_addr == 4'h3
        |=> reg_rdata == $past(status_now))
        else $error("status read wrong");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    done_rise_a: assert property ($rose(transfer_done_flag)
        |-> !scl_in && bus_busy_flag)
        else $error("done set outside a byte end");
    addr_rise_a: assert property ($rose(target_addressed_flag)
        |-> !scl_in && bus_busy_flag)
        else $error("addressed set outside address byte");
    done_drop_a: assert property ($fell(transfer_done_flag)
        |-> scl_in || $past(reg_read) || $past(reg_write))
        else $error("done cleared without cause");
endmodule // isf_status_flags_properties

// ---- bench/isf_bus_ctrl_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Remote controller on the two-wire bus, 160 ns bit period
// ----------------------------------------------------------------
// A released line reads high as its pull-up makes it; the clock
// line stands high between frames.
module isf_bus_ctrl_model (
    output logic scl,
    output logic sda
);
    // Idle bus at time zero
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Start or repeated start: data falls while clock is high
    task automatic start_frame();
        sda = 1'b1;
        #40;
        scl = 1'b1;
        #40;
        sda = 1'b0;
        #80;
        scl = 1'b0;
        #40;
    endtask
    // Eight bits MSB first; data moves only while clock is low
    task automatic send_bits(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            #40;
            scl = 1'b1;
            #80;
            scl = 1'b0;
            #40;
        end
    endtask
    // Ninth clock with data released
    task automatic ack_clock();
        sda = 1'b1;
        #40;
        scl = 1'b1;
        #80;
        scl = 1'b0;
        #40;
    endtask
    // Stop: data rises while clock is high
    task automatic stop_frame();
        sda = 1'b0;
        #40;
        scl = 1'b1;
        #40;
        sda = 1'b1;
        #80;
    endtask
endmodule // isf_bus_ctrl_model

// ---- bench/isf_status_flags_tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the status flags
// ----------------------------------------------------------------
module isf_status_flags_tb;
    logic clock;
    logic arst_n;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    wire [7:0] reg_rdata;
    wire scl;
    wire sda;
    wire transfer_done_flag;
    wire target_addressed_flag;
    wire bus_busy_flag;
    wire target_rw_indication;
    logic [7:0] rd_data;
    logic [8:0] cases [12];
    int fail_count;
    int n_tests;

    isf_status_flags i_isf_status_flags (.clock(clock), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl),
        .sda_in(sda), .transfer_done_flag(transfer_done_flag),
        .target_addressed_flag(target_addressed_flag),
        .bus_busy_flag(bus_busy_flag),
        .target_rw_indication(target_rw_indication));
    isf_bus_ctrl_model i_isf_bus_ctrl_model (.scl(scl), .sda(sda));

    // System clock, 8 ns
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t read %h want %h", $time, got, exp);
        end
    endtask
    // Flags {done, addressed, busy, rw}, sampled once the sync has caught up
    task automatic chk_flags(input logic [3:0] exp,
        input logic [3:0] mask = 4'hF);
        logic [3:0] got;
        repeat (8) @(posedge clock);
        #1;
        got = {transfer_done_flag, target_addressed_flag, bus_busy_flag,
            target_rw_indication} & mask;
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t flags %b want %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        // Step off the edge so line changes that follow never race it
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Watchdog: the whole run needs well under 100 us
    initial begin
        #200000;
        fail_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        fail_count = 0;
        n_tests = 0;
        // {enable, addressed, calling address}; 0x21..0x28 is the window
        cases = '{9'h180, 9'h18C, 9'h1D0, 9'h1A1, 9'h1A8, 9'h129,
            9'h000, 9'h00C, 9'h050, 9'h024, 9'h028, 9'h0A0};
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd(4'h3, rd_data);
        chk_reg(rd_data, 8'h00);
        rd(4'hF, rd_data);
        chk_reg(rd_data, 8'h00);
        wr(4'h0, 8'h40);
        wr(4'h6, 8'h50);
        wr(4'h8, 8'hA0);
        wr(4'h5, 8'h88);
        wr(4'h7, 8'h0A);
        // Primary address, remote controller writing
        i_isf_bus_ctrl_model.start_frame();
        chk_flags(4'b0010);
        i_isf_bus_ctrl_model.send_bits(8'h40);
        chk_flags(4'b0110);
        i_isf_bus_ctrl_model.ack_clock();
        chk_flags(4'b1110);
        rd(4'h3, rd_data);
        chk_reg(rd_data, 8'hE0);
        wr(4'h3, 8'h00);
        chk_flags(4'b1110);
        i_isf_bus_ctrl_model.send_bits(8'h5A);
        chk_flags(4'b0110);
        i_isf_bus_ctrl_model.ack_clock();
        wr(4'h4, 8'h33);
        chk_flags(4'b1110);
        rd(4'h4, rd_data);
        chk_reg(rd_data, 8'h5A);
        chk_flags(4'b0110);
        wr(4'h2, 8'h10);
        chk_flags(4'b0010);
        i_isf_bus_ctrl_model.send_bits(8'hC3);
        i_isf_bus_ctrl_model.ack_clock();
        rd(4'h4, rd_data);
        chk_reg(rd_data, 8'h33);
        chk_flags(4'b1010);
        wr(4'h4, 8'h66);
        chk_flags(4'b0010);
        i_isf_bus_ctrl_model.stop_frame();
        chk_flags(4'b0000);
        // Every address source, enabled and disabled, controller reading
        for (int k = 0; k < 12; k++) begin
            wr(4'h5, cases[k][8] ? 8'h88 : 8'h00);
            wr(4'h7, cases[k][8] ? 8'h0A : 8'h00);
            i_isf_bus_ctrl_model.start_frame();
            i_isf_bus_ctrl_model.send_bits({cases[k][6:0], 1'b1});
            i_isf_bus_ctrl_model.ack_clock();
            chk_flags({cases[k][7], cases[k][7], 1'b1, cases[k][7]},
                {3'b111, cases[k][7]});
            wr(4'h2, 8'h10);
            i_isf_bus_ctrl_model.stop_frame();
        end
        finish_test();
    end
endmodule // isf_status_flags_tb

bind isf_status_flags isf_status_flags_properties
    i_isf_status_flags_properties (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .sda_in(sda_in), .transfer_done_flag(transfer_done_flag),
    .target_addressed_flag(target_addressed_flag),
    .bus_busy_flag(bus_busy_flag),
    .target_rw_indication(target_rw_indication));
